//--- dv/rsfsr_stats_model.sv
// Purpose: Running statistics counters that sit on the increment outputs of the status block.
// Assumes: Same receive clock as the block; totals clear with the block's reset.
// Notes:   Totals are 32 bits wide and wrap, which is far beyond any run of the bench.
`timescale 1ns/1ps

module rsfsr_stats_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Increments from the block
  input  wire logic        corr_incr,
  input  wire logic        unc_incr,
  input  wire logic [2:0]  l0_incr,
  input  wire logic [2:0]  l1_incr,
  // Running totals
  output logic      [31:0] corr_total,
  output logic      [31:0] unc_total,
  output logic      [31:0] l0_total,
  output logic      [31:0] l1_total
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      corr_total <= 32'h0;
      unc_total  <= 32'h0;
      l0_total   <= 32'h0;
      l1_total   <= 32'h0;
    end else begin
      corr_total <= corr_total + 32'(corr_incr);
      unc_total  <= unc_total + 32'(unc_incr);
      l0_total   <= l0_total + 32'(l0_incr);
      l1_total   <= l1_total + 32'(l1_incr);
    end
  end
endmodule

//--- dv/test_rsfsr_status.sv
// Purpose: Self-checking bench of the receive FEC status block with a statistics model.
// Assumes: Outputs lag the sampled inputs by exactly one clock.
// Notes:   A short monitor window keeps the threshold cases within a few dozen cycles.
`timescale 1ns/1ps

module test_rsfsr_status;
  localparam int unsigned WCW = 4;
  logic        clk, rst_n, byp, aln, done, corr, unc, aln_o, flag, c_inc, u_inc;
  logic [1:0]  map, map_o;
  logic [6:0]  w0, f0, w1, f1;
  logic [2:0]  e0, e1, s0, s1;
  logic [13:0] fill0, fill1;
  logic [31:0] t_c, t_u, t_0, t_1, m_c, m_u, m_0, m_1;
  int          err_count = 0, n_compared = 0, cycles = 0, acc, cnt, k;
  logic        x_flag;

  rsfsr_status #(.WINDOW_CW(WCW)) i_dut (.clk(clk), .rst_n(rst_n), .bypass_indication_mode(byp),
    .lanes_aligned_in(aln), .lane_map_in(map), .lane0_whole_in(w0), .lane0_frac_in(f0),
    .lane1_whole_in(w1), .lane1_frac_in(f1), .cw_done(done), .cw_corrected(corr),
    .cw_uncorrectable(unc), .lane0_sym_err(e0), .lane1_sym_err(e1), .lane_alignment_status(aln_o),
    .lane_mapping(map_o), .lane0_fill(fill0), .lane1_fill(fill1), .high_symbol_error_rate_flag(flag),
    .corrected_codeword_incr(c_inc), .uncorrectable_codeword_incr(u_inc),
    .lane0_symbol_error_incr(s0), .lane1_symbol_error_incr(s1));
  rsfsr_stats_model i_stats (.clk(clk), .rst_n(rst_n), .corr_incr(c_inc), .unc_incr(u_inc),
    .l0_incr(s0), .l1_incr(s1), .corr_total(m_c), .unc_total(m_u), .l0_total(m_0), .l1_total(m_1));

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [6:0] clamp(input logic [6:0] f);
    return (f >= rsfsr_pkg::FRAC_STEPS) ? rsfsr_pkg::FRAC_MAX : f;
  endfunction

  // One cycle of stimulus; the bench's own monitor model predicts the flag.
  task automatic step(input logic b, input logic d, input logic c, input logic u,
                      input logic [2:0] a0, input logic [2:0] a1);
    logic xc, xu;
    {byp, done, corr, unc, e0, e1} = {b, d, c, u, a0, a1};
    {aln, map, w0, f0, w1, f1} = 31'($urandom);
    xc = d & c & ~u;
    xu = d & u;
    if (!b) begin
      {acc, cnt, x_flag} = '0;
    end else begin
      acc = (acc + a0 + a1 > 1023) ? 1023 : acc + a0 + a1;
      if (d && cnt == WCW - 1) begin
        x_flag = (acc > 417);
        {acc, cnt} = '0;
      end else if (d) cnt++;
    end
    {t_c, t_u, t_0, t_1} = {t_c + xc, t_u + xu, t_0 + a0, t_1 + a1};
    @(posedge clk);
    #1;
    check("lane_alignment_status", 32'(aln_o), 32'(aln));
    check("lane_mapping", 32'(map_o), 32'(map));
    check("lane0_fill", 32'(fill0), {18'h0, w0, clamp(f0)});
    check("lane1_fill", 32'(fill1), {18'h0, w1, clamp(f1)});
    check("high_symbol_error_rate_flag", 32'(flag), 32'(x_flag));
    check("corrected_codeword_incr", 32'(c_inc), 32'(xc));
    check("uncorrectable_codeword_incr", 32'(u_inc), 32'(xu));
    check("lane0_symbol_error_incr", 32'(s0), 32'(a0));
    check("lane1_symbol_error_incr", 32'(s1), 32'(a1));
  endtask

  task automatic do_reset(input int n);
    {byp, done, corr, unc, e0, e1, acc, cnt, x_flag} = '0;
    {t_c, t_u, t_0, t_1} = '0;
    rst_n = 0;
    #1;
    check("outputs in reset", {20'h0, aln_o, map_o, flag, c_inc, u_inc, s0, s1}, 32'h0);
    check("fills in reset", {4'h0, fill0, fill1}, 32'h0);
    repeat (n) @(posedge clk);
    #1 rst_n = 1;
    // Inputs are first taken at the third edge after release.
    repeat (4) @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // Clock, timeout and main sequence
  // ==========================================================================
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h6c21));
    {aln, map, w0, f0, w1, f1} = '0;
    do_reset(20);
    // Dense, medium and sparse codeword ends; bypass drops about one cycle in 16, clearing the sum long before saturation.
    for (int p = 0; p < 3; p++) begin
      k = (p == 0) ? 1 : (p == 1) ? 4 : 40;
      repeat (400) step($urandom % 16 != 0, $urandom % k == 0, $urandom, $urandom, $urandom, $urandom);
    end
    // Window sums of exactly the threshold and one above it, then bypass off clears the flag.
    for (int lim = 417; lim <= 418; lim++) begin
      step(0, 0, 0, 0, 0, 0);
      repeat (29) step(1, 0, 0, 0, 7, 7);
      repeat (3) step(1, 1, 1, 0, 0, 0);
      step(1, 1, 0, 1, 7, 3'(lim - 413));
      repeat (3) step(1, 0, 0, 0, 0, 0);
    end
    step(0, 0, 0, 0, 0, 0);
    // Hand-set deskew words: a lane 0 fraction that must clamp and a packed lane 1 word.
    {aln, map, w0, f0, w1, f1} = {1'b1, 2'h2, 7'h7f, 7'h7f, 7'h05, 7'h10};
    @(posedge clk);
    #1;
    check("lane_alignment_status corner", 32'(aln_o), 32'h1);
    check("lane_mapping corner", 32'(map_o), 32'h2);
    check("lane0_fill clamp", 32'(fill0), 32'h3fc1);
    check("lane1_fill packed", 32'(fill1), 32'h0290);
    check("corrected total before reset", m_c, t_c);
    check("uncorrectable total before reset", m_u, t_u);
    check("lane0 error total before reset", m_0, t_0);
    check("lane1 error total before reset", m_1, t_1);
    do_reset(2);
    repeat (200) step($urandom % 2, $urandom % 2, $urandom, $urandom, $urandom, $urandom);
    repeat (2) step(0, 0, 0, 0, 0, 0);
    check("corrected total", m_c, t_c);
    check("uncorrectable total", m_u, t_u);
    check("lane0 error total", m_0, t_0);
    check("lane1 error total", m_1, t_1);
    conclude();
  end
endmodule

//--- hdl/rsfsr_pkg.sv
// Purpose: Shared constants for the receive FEC status reporting block.
// Assumes: One receive core clock; all inputs synchronous to it.
// Notes:   Field positions of the deskew delay words and the high symbol-error-rate limits.
package rsfsr_pkg;

  // ==========================================================================
  // Deskew delay word layout
  // ==========================================================================
  localparam int unsigned FILL_W       = 14;
  localparam int unsigned FILL_WHOLE_H = 13;
  localparam int unsigned FILL_WHOLE_L = 7;
  localparam int unsigned FILL_FRAC_H  = 6;
  localparam int unsigned FILL_FRAC_L  = 0;
  localparam int unsigned PART_W       = 7;
  // Fraction is counted in 1/66th of a cycle, so the largest legal step is 65.
  localparam logic [6:0]  FRAC_STEPS   = 7'h42;
  localparam logic [6:0]  FRAC_MAX     = 7'h41;

  // ==========================================================================
  // Lane mapping and increments
  // ==========================================================================
  localparam int unsigned MAP_W        = 2;
  localparam int unsigned SYM_INC_W    = 3;

  // ==========================================================================
  // High symbol-error-rate monitor
  // ==========================================================================
  localparam int unsigned SER_WINDOW_CW = 8192;
  localparam int unsigned SER_CNT_W     = 13;
  localparam int unsigned SER_ACC_W     = 10;
  localparam logic [9:0]  SER_THRESHOLD = 10'h1a1;
  localparam logic [9:0]  SER_ACC_MAX   = 10'h3ff;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [13:0] FILL_RST      = 14'h0000;
  localparam logic [1:0]  MAP_RST       = 2'h0;
  localparam logic [2:0]  SYM_INC_RST   = 3'h0;

endpackage

//--- hdl/rsfsr_status.sv
// Purpose: Receive-side status and statistics increments of a two-lane RS-FEC decoder.
// Assumes: Decoder core logic supplies per-codeword flags and per-cycle symbol error counts.
// Notes:   Every output is registered, so all reports lag their cause by one clock.
//
// Summary of operation
// - Bits 13:7 of the lane 0 deskew delay word give the whole extra cycles inserted by deskew.
// - Bits 6:0 of each deskew delay word give the fractional delay in sixty-sixths of a cycle.
// - Lane 1 has its own 14-bit deskew delay word laid out like lane 0.
// - The 2-bit lane mapping gives, per bit, the FEC lane index carried on the matching PMA lane.
// - The high symbol-error-rate flag is driven only in bypass indication mode and is low otherwise.
// - The flag rises when symbol errors over a window of 8192 codewords exceed 417.
// - A one-cycle increment pulses for each codeword whose errors were corrected.
// - A separate one-cycle increment pulses for each codeword that could not be corrected.
// - A 3-bit value gives the lane 0 symbol errors found in the current cycle.
// - A 3-bit value gives the lane 1 symbol errors found in the current cycle.
// - A one-bit alignment status reads 0 while unaligned and 1 once aligned.
`timescale 1ns/1ps

module rsfsr_status #(
  parameter int unsigned WINDOW_CW = rsfsr_pkg::SER_WINDOW_CW
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Mode
  input  wire logic        bypass_indication_mode,
  // Deskew and alignment from the lane aligner
  input  wire logic        lanes_aligned_in,
  input  wire logic [1:0]  lane_map_in,
  input  wire logic [6:0]  lane0_whole_in,
  input  wire logic [6:0]  lane0_frac_in,
  input  wire logic [6:0]  lane1_whole_in,
  input  wire logic [6:0]  lane1_frac_in,
  // Decoder events
  input  wire logic        cw_done,
  input  wire logic        cw_corrected,
  input  wire logic        cw_uncorrectable,
  input  wire logic [2:0]  lane0_sym_err,
  input  wire logic [2:0]  lane1_sym_err,
  // Status outputs
  output logic             lane_alignment_status,
  output logic [1:0]       lane_mapping,
  output logic [13:0]      lane0_fill,
  output logic [13:0]      lane1_fill,
  output logic             high_symbol_error_rate_flag,
  // Statistics increments
  output logic             corrected_codeword_incr,
  output logic             uncorrectable_codeword_incr,
  output logic [2:0]       lane0_symbol_error_incr,
  output logic [2:0]       lane1_symbol_error_incr
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Deskew, mapping and alignment status
  // ==========================================================================
  logic [13:0] lane0_fill_reg;
  logic [13:0] lane0_fill_next;
  logic [13:0] lane1_fill_reg;
  logic [13:0] lane1_fill_next;
  logic [1:0]  lane_map_reg;
  logic [1:0]  lane_map_next;
  logic        aligned_reg;
  logic        aligned_next;

  // A fraction of 66 or more would mean a whole cycle; clamp so the word never overflows its unit.
  function automatic logic [6:0] frac_clamp(input logic [6:0] f);
    frac_clamp = (f >= rsfsr_pkg::FRAC_STEPS) ? rsfsr_pkg::FRAC_MAX : f;
  endfunction

  always_comb begin
    lane0_fill_next = {lane0_whole_in, frac_clamp(lane0_frac_in)};
    lane1_fill_next = {lane1_whole_in, frac_clamp(lane1_frac_in)};
    lane_map_next   = lane_map_in;
    aligned_next    = lanes_aligned_in;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lane0_fill_reg <= rsfsr_pkg::FILL_RST;
      lane1_fill_reg <= rsfsr_pkg::FILL_RST;
      lane_map_reg   <= rsfsr_pkg::MAP_RST;
      aligned_reg    <= 1'b0;
    end else begin
      lane0_fill_reg <= lane0_fill_next;
      lane1_fill_reg <= lane1_fill_next;
      lane_map_reg   <= lane_map_next;
      aligned_reg    <= aligned_next;
    end
  end

  assign lane0_fill            = lane0_fill_reg;
  assign lane1_fill            = lane1_fill_reg;
  assign lane_mapping          = lane_map_reg;
  assign lane_alignment_status = aligned_reg;

  // ==========================================================================
  // Statistics increments
  // ==========================================================================
  logic       corr_inc_reg;
  logic       corr_inc_next;
  logic       uncorr_inc_reg;
  logic       uncorr_inc_next;
  logic [2:0] l0_inc_reg;
  logic [2:0] l0_inc_next;
  logic [2:0] l1_inc_reg;
  logic [2:0] l1_inc_next;

  // A codeword flagged both ways counts only as uncorrectable, so one codeword never bumps both counters.
  always_comb begin
    corr_inc_next   = cw_done && cw_corrected && !cw_uncorrectable;
    uncorr_inc_next = cw_done && cw_uncorrectable;
    l0_inc_next     = lane0_sym_err;
    l1_inc_next     = lane1_sym_err;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      corr_inc_reg   <= 1'b0;
      uncorr_inc_reg <= 1'b0;
      l0_inc_reg     <= rsfsr_pkg::SYM_INC_RST;
      l1_inc_reg     <= rsfsr_pkg::SYM_INC_RST;
    end else begin
      corr_inc_reg   <= corr_inc_next;
      uncorr_inc_reg <= uncorr_inc_next;
      l0_inc_reg     <= l0_inc_next;
      l1_inc_reg     <= l1_inc_next;
    end
  end

  assign corrected_codeword_incr     = corr_inc_reg;
  assign uncorrectable_codeword_incr = uncorr_inc_reg;
  assign lane0_symbol_error_incr     = l0_inc_reg;
  assign lane1_symbol_error_incr     = l1_inc_reg;

  // ==========================================================================
  // High symbol-error-rate monitor
  // ==========================================================================
  localparam logic [12:0] WIN_LAST = 13'(WINDOW_CW - 1);

  logic [12:0] cw_cnt_reg;
  logic [12:0] cw_cnt_next;
  logic [9:0]  err_acc_reg;
  logic [9:0]  err_acc_next;
  logic        hi_ser_reg;
  logic        hi_ser_next;
  logic [10:0] err_sum;
  logic [9:0]  err_sat;
  logic        win_end;

  // The verdict of one window is held through the next, so in bypass indication mode the flag can only change at a window end.
  always_comb begin
    err_sum      = {1'b0, err_acc_reg} + {8'h00, lane0_sym_err} + {8'h00, lane1_sym_err};
    err_sat      = err_sum[10] ? rsfsr_pkg::SER_ACC_MAX : err_sum[9:0];
    win_end      = cw_done && (cw_cnt_reg == WIN_LAST);
    cw_cnt_next  = cw_cnt_reg;
    err_acc_next = err_sat;
    hi_ser_next  = hi_ser_reg;
    if (cw_done) begin
      cw_cnt_next = win_end ? 13'h0000 : cw_cnt_reg + 13'h0001;
    end
    if (win_end) begin
      err_acc_next = 10'h000;
      hi_ser_next  = err_sat > rsfsr_pkg::SER_THRESHOLD;
    end
    if (!bypass_indication_mode) begin
      cw_cnt_next  = 13'h0000;
      err_acc_next = 10'h000;
      hi_ser_next  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cw_cnt_reg  <= 13'h0000;
      err_acc_reg <= 10'h000;
      hi_ser_reg  <= 1'b0;
    end else begin
      cw_cnt_reg  <= cw_cnt_next;
      err_acc_reg <= err_acc_next;
      hi_ser_reg  <= hi_ser_next;
    end
  end

  assign high_symbol_error_rate_flag = hi_ser_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);
  // Checks that expect a value taken from the inputs one cycle back are armed only once the synchronised reset was already high, because the
  // first edge after release still shows reset values whatever the inputs were.

  lane0_whole_a: assert property (rst_sync_n |=> lane0_fill[13:7] == $past(lane0_whole_in))
    else $error("lane 0 whole delay does not follow its source");

  fill_frac_a: assert property ((lane0_fill[6:0] < rsfsr_pkg::FRAC_STEPS) &&
                                (lane1_fill[6:0] < rsfsr_pkg::FRAC_STEPS))
    else $error("fractional delay out of its sixty-sixths range");

  lane1_fill_a: assert property (rst_sync_n && (lane1_whole_in == 7'h05) && (lane1_frac_in == 7'h10)
                                 |=> lane1_fill == 14'h0290)
    else $error("lane 1 delay word wrongly packed");

  map_follow_a: assert property (rst_sync_n |=> lane_mapping == $past(lane_map_in))
    else $error("lane mapping does not follow the aligner");

  hiser_mode_a: assert property (!bypass_indication_mode |=> !high_symbol_error_rate_flag)
    else $error("high error rate flag set outside bypass indication mode");

  hiser_rise_a: assert property (rst_sync_n && bypass_indication_mode && win_end
                                 && (err_sat > rsfsr_pkg::SER_THRESHOLD)
                                 |=> high_symbol_error_rate_flag)
    else $error("high error rate flag missed an excess window");

  hiser_hold_a: assert property (!win_end && bypass_indication_mode
                                 |=> $stable(high_symbol_error_rate_flag))
    else $error("high error rate flag changed inside a window");

  corr_pulse_a: assert property (rst_sync_n && cw_done && cw_corrected && !cw_uncorrectable
                                 |=> corrected_codeword_incr && !uncorrectable_codeword_incr)
    else $error("corrected codeword increment missing");

  uncorr_pulse_a: assert property (rst_sync_n && cw_done && cw_uncorrectable |=> uncorrectable_codeword_incr)
    else $error("uncorrectable codeword increment missing");

  idle_zero_a: assert property (!cw_done |=> !corrected_codeword_incr && !uncorrectable_codeword_incr)
    else $error("codeword increment without a codeword");

  sym_err_a: assert property (rst_sync_n |=> (lane0_symbol_error_incr == $past(lane0_sym_err)) &&
                              (lane1_symbol_error_incr == $past(lane1_sym_err)))
    else $error("symbol error increment does not match the decoder");

  align_follow_a: assert property (rst_sync_n && lanes_aligned_in ##1 lanes_aligned_in |-> lane_alignment_status)
    else $error("alignment status low while lanes aligned");

  align_low_a: assert property (rst_sync_n && !lanes_aligned_in |=> !lane_alignment_status)
    else $error("alignment status high while lanes unaligned");

  lane0_frac_a: assert property (rst_sync_n && (lane0_frac_in < rsfsr_pkg::FRAC_STEPS)
                                 |=> lane0_fill[6:0] == $past(lane0_frac_in))
    else $error("lane 0 fractional delay does not follow its source");

  frac_clamp_a: assert property (rst_sync_n && (lane1_frac_in >= rsfsr_pkg::FRAC_STEPS)
                                 |=> lane1_fill[6:0] == rsfsr_pkg::FRAC_MAX)
    else $error("lane 1 fractional delay not clamped");

  lane1_whole_a: assert property (rst_sync_n |=> lane1_fill[13:7] == $past(lane1_whole_in))
    else $error("lane 1 whole delay does not follow its source");

  incr_excl_a: assert property (!(corrected_codeword_incr && uncorrectable_codeword_incr))
    else $error("one codeword counted both corrected and uncorrectable");

  sym_idle_a: assert property (rst_sync_n && (lane0_sym_err == 3'h0) && (lane1_sym_err == 3'h0)
                               |=> (lane0_symbol_error_incr == 3'h0) && (lane1_symbol_error_incr == 3'h0))
    else $error("symbol error increment without a symbol error");

  // ==========================================================================
  // Window monitor checks
  // ==========================================================================
  // A verdict taken from a clean window must drop the flag, not merely hold it.
  hiser_fall_a: assert property (rst_sync_n && bypass_indication_mode && win_end
                                 && (err_sat <= rsfsr_pkg::SER_THRESHOLD)
                                 |=> !high_symbol_error_rate_flag)
    else $error("high error rate flag kept after a clean window");

  win_range_a: assert property (cw_cnt_reg <= WIN_LAST)
    else $error("codeword window counter past its last value");

  mode_clear_a: assert property (!bypass_indication_mode
                                 |=> (cw_cnt_reg == 13'h0000) && (err_acc_reg == 10'h000))
    else $error("monitor state kept outside bypass indication mode");

  acc_grow_a: assert property (rst_sync_n && bypass_indication_mode && !win_end
                               |=> err_acc_reg >= $past(err_acc_reg))
    else $error("error accumulator fell inside a window");

  win_clear_a: assert property (rst_sync_n && bypass_indication_mode && win_end
                                |=> (cw_cnt_reg == 13'h0000) && (err_acc_reg == 10'h000))
    else $error("window not restarted after its end");

  cnt_step_a: assert property (rst_sync_n && bypass_indication_mode && cw_done && !win_end
                               |=> cw_cnt_reg == $past(cw_cnt_reg) + 13'h0001)
    else $error("codeword window counter missed a codeword");

  cnt_hold_a: assert property (bypass_indication_mode && !cw_done |=> $stable(cw_cnt_reg))
    else $error("codeword window counter moved without a codeword");

endmodule
